// File: hw/albk_bucket.sv
// Behaviour
// - judge the input once per 128 ms monitoring cycle.
// - each failed or erratic cycle adds one to the accumulator.
// - each run of 1, 2, 4 or 8 clean cycles subtracts one.
// - accumulator never exceeds the programmed maximum count after a cycle end, except a count written in the cycle end clock.
// - alarm raises when the accumulator reaches the upper threshold.
// - alarm clears when the accumulator decays to the lower threshold.
`timescale 1ns/1ns
`default_nettype none
module albk_bucket
   import albk_pkg::*;
#(
   parameter int CYCLE_CLKS_P = CYCLE_CLKS
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // activity monitor
   input  wire logic       fault_in,
   // register port
   input  wire albk_req_t  req,
   output logic [7:0]      rdata,
   // results
   output logic [7:0]      level,
   output logic            alarm,
   output logic            cycle_tick
);
   if (CYCLE_CLKS_P < 2) begin : g_len_check
      $error("cycle length too short");
   end

   ////////////////////////////////////////////////////////////////
   typedef struct packed {
      albk_cfg_t  cfg;
      logic [31:0] div;
      logic        tick;
      logic        fault_seen;
      logic [2:0]  clean_run;
      logic [7:0]  acc;
      logic        alarm;
      logic [7:0]  rdata;
      logic        f1;
      logic        f2;
   } st_t;

   st_t s_q;
   st_t s_d;

   function automatic logic [3:0] run_len(input logic [1:0] sel);
      case (sel)
         2'h0:    run_len = 4'h1;
         2'h1:    run_len = 4'h2;
         2'h2:    run_len = 4'h4;
         default: run_len = 4'h8;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////
   always_comb begin
      s_d      = s_q;
      s_d.f1   = fault_in;
      s_d.f2   = s_q.f1;
      s_d.tick = 1'b0;
      // register writes
      if (req.wr) begin
         case (req.addr)
            ADDR_UPPER_THR: s_d.cfg.upper_thr = req.wdata;
            ADDR_LOWER_THR: s_d.cfg.lower_thr = req.wdata;
            ADDR_MAX_COUNT: s_d.cfg.max_count = req.wdata;
            ADDR_LEAK_RATE: s_d.cfg.leak_rate = {6'h00, req.wdata[LEAK_SEL_MSB:LEAK_SEL_LSB]};
            default:        s_d.rdata = s_q.rdata;
         endcase
      end
      // register reads
      if (req.rd) begin
         case (req.addr)
            ADDR_UPPER_THR: s_d.rdata = s_q.cfg.upper_thr;
            ADDR_LOWER_THR: s_d.rdata = s_q.cfg.lower_thr;
            ADDR_MAX_COUNT: s_d.rdata = s_q.cfg.max_count;
            ADDR_LEAK_RATE: s_d.rdata = s_q.cfg.leak_rate;
            ADDR_STATUS:    s_d.rdata = {7'h00, s_q.alarm};
            default:        s_d.rdata = 8'h00;
         endcase
      end
      // cycle divider and fault capture
      if (s_q.f2) begin
         s_d.fault_seen = 1'b1;
      end
      if (s_q.div == 32'(CYCLE_CLKS_P - 1)) begin
         s_d.div        = 32'h00000000;
         s_d.tick       = 1'b1;
         s_d.fault_seen = 1'b0;
         if (s_q.fault_seen || s_q.f2) begin
            s_d.clean_run = 3'h0;
            if (s_q.acc < s_q.cfg.max_count) begin
               s_d.acc = s_q.acc + 8'h01;
            end
         end else if ({1'b0, s_q.clean_run} + 4'h1 >=
                      run_len(s_q.cfg.leak_rate[LEAK_SEL_MSB:LEAK_SEL_LSB])) begin
            s_d.clean_run = 3'h0;
            if (s_q.acc != 8'h00) begin
               s_d.acc = s_q.acc - 8'h01;
            end
         end else begin
            s_d.clean_run = s_q.clean_run + 3'h1;
         end
         if (s_q.acc > s_q.cfg.max_count) begin
            s_d.acc = s_q.cfg.max_count;
         end
      end else begin
         s_d.div = s_q.div + 32'h00000001;
      end
      // alarm hysteresis
      if (s_q.acc >= s_q.cfg.upper_thr) begin
         s_d.alarm = 1'b1;
      end else if (s_q.acc <= s_q.cfg.lower_thr) begin
         s_d.alarm = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q               <= '0;
         s_q.cfg.upper_thr <= RST_UPPER_THR;
         s_q.cfg.lower_thr <= RST_LOWER_THR;
         s_q.cfg.max_count <= RST_MAX_COUNT;
         s_q.cfg.leak_rate <= RST_LEAK_RATE;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////
   assign rdata      = s_q.rdata;
   assign level      = s_q.acc;
   assign alarm      = s_q.alarm;
   assign cycle_tick = s_q.tick;

   ////////////////////////////////////////////////////////////////
   sequence wrap_fault;
      s_q.div == 32'(CYCLE_CLKS_P - 1) && (s_q.fault_seen || s_q.f2);
   endsequence

   sequence wrap_clean;
      s_q.div == 32'(CYCLE_CLKS_P - 1) && !(s_q.fault_seen || s_q.f2);
   endsequence

   AST_TICK_SPACING: assert property (@(posedge clk) disable iff (rst)
      $rose(s_q.tick) |=> !s_q.tick [*1])
      else $error("cycle ticks back to back");

   AST_TICK_AT_WRAP: assert property (@(posedge clk) disable iff (rst)
      s_q.div == 32'(CYCLE_CLKS_P - 1) |=> s_q.tick && s_q.div == 32'h0)
      else $error("cycle tick not at divider wrap");

   AST_DIV_RANGE: assert property (@(posedge clk) disable iff (rst)
      s_q.div < 32'(CYCLE_CLKS_P))
      else $error("divider beyond cycle length");

   AST_FAULT_CAPTURE: assert property (@(posedge clk) disable iff (rst)
      (s_q.f2 && s_q.div != 32'(CYCLE_CLKS_P - 1)) |=> s_q.fault_seen)
      else $error("fault sample not held for the cycle");

   AST_LEVEL_STILL: assert property (@(posedge clk) disable iff (rst)
      s_q.div != 32'(CYCLE_CLKS_P - 1) |=> $stable(s_q.acc))
      else $error("accumulator moved inside a cycle");

   AST_INC: assert property (@(posedge clk) disable iff (rst)
      wrap_fault ##0 (s_q.acc < s_q.cfg.max_count && !req.wr) |=> s_q.acc == $past(s_q.acc) + 8'h01)
      else $error("failure cycle did not add one");

   AST_DEC: assert property (@(posedge clk) disable iff (rst)
      wrap_clean ##0 (s_q.acc != 8'h00 && s_q.acc <= s_q.cfg.max_count && s_q.cfg.leak_rate[1:0] == 2'h0)
      |=> s_q.acc == $past(s_q.acc) - 8'h01)
      else $error("clean cycle did not leak at fastest rate");

   AST_NO_EARLY_LEAK: assert property (@(posedge clk) disable iff (rst)
      wrap_clean ##0 ({1'b0, s_q.clean_run} + 4'h1 < run_len(s_q.cfg.leak_rate[1:0])
      && s_q.acc <= s_q.cfg.max_count) |=> s_q.acc == $past(s_q.acc))
      else $error("leak before clean run complete");

   AST_SAT: assert property (@(posedge clk) disable iff (rst)
      (s_q.tick && !$past(req.wr)) |-> s_q.acc <= $past(s_q.cfg.max_count))
      else $error("accumulator above maximum");

   AST_RUN: assert property (@(posedge clk) disable iff (rst)
      s_q.tick |-> {1'b0, s_q.clean_run} < run_len($past(s_q.cfg.leak_rate[1:0])))
      else $error("clean run exceeds selected length");

   AST_FLOOR: assert property (@(posedge clk) disable iff (rst)
      wrap_clean ##0 (s_q.acc == 8'h00) |=> s_q.acc == 8'h00)
      else $error("accumulator wrapped below zero");

   AST_RESTART: assert property (@(posedge clk) disable iff (rst)
      wrap_fault |=> s_q.clean_run == 3'h0)
      else $error("failure cycle did not restart clean run");

   AST_RAISE: assert property (@(posedge clk) disable iff (rst)
      (s_q.acc >= s_q.cfg.upper_thr) |=> s_q.alarm)
      else $error("alarm not raised at upper threshold");

   AST_RISE_CAUSE: assert property (@(posedge clk) disable iff (rst)
      $rose(s_q.alarm) |-> $past(s_q.acc) >= $past(s_q.cfg.upper_thr))
      else $error("alarm raised below upper threshold");

   AST_CLEAR: assert property (@(posedge clk) disable iff (rst)
      (s_q.acc <= s_q.cfg.lower_thr && s_q.acc < s_q.cfg.upper_thr) |=> !s_q.alarm)
      else $error("alarm not cleared at lower threshold");

   AST_FALL_CAUSE: assert property (@(posedge clk) disable iff (rst)
      $fell(s_q.alarm) |-> $past(s_q.acc) <= $past(s_q.cfg.lower_thr))
      else $error("alarm cleared above lower threshold");

   AST_ALARM_HOLD: assert property (@(posedge clk) disable iff (rst)
      (s_q.acc < s_q.cfg.upper_thr && s_q.acc > s_q.cfg.lower_thr) |=> $stable(s_q.alarm))
      else $error("alarm changed between thresholds");

   AST_STATUS_READ: assert property (@(posedge clk) disable iff (rst)
      (req.rd && req.addr == ADDR_STATUS) |=> rdata == {7'h00, $past(s_q.alarm)})
      else $error("status read does not show alarm");
endmodule
`default_nettype wire

// File: include/albk_pkg.sv
`default_nettype none
package albk_pkg;
   // register map
   localparam logic [7:0] ADDR_UPPER_THR   = 8'h50;
   localparam logic [7:0] ADDR_LOWER_THR   = 8'h51;
   localparam logic [7:0] ADDR_MAX_COUNT   = 8'h52;
   localparam logic [7:0] ADDR_LEAK_RATE   = 8'h53;
   localparam logic [7:0] ADDR_STATUS      = 8'h54;
   // reset values
   localparam logic [7:0] RST_UPPER_THR    = 8'h06;
   localparam logic [7:0] RST_LOWER_THR    = 8'h04;
   localparam logic [7:0] RST_MAX_COUNT    = 8'h08;
   localparam logic [7:0] RST_LEAK_RATE    = 8'h01;
   // field layout
   localparam int         LEAK_SEL_MSB     = 1;
   localparam int         LEAK_SEL_LSB     = 0;
   localparam int         STAT_ALARM_BIT   = 0;
   // timing
   localparam int         CLK_HZ           = 10_000_000;
   localparam int         CYCLE_MS         = 128;
   localparam int         CYCLE_CLKS       = CLK_HZ / 1000 * CYCLE_MS;

   typedef struct packed {
      logic [7:0] upper_thr;
      logic [7:0] lower_thr;
      logic [7:0] max_count;
      logic [7:0] leak_rate;
   } albk_cfg_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } albk_req_t;
endpackage
`default_nettype wire

// File: tb/albk_bucket_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module albk_bucket_tb_top;
   import albk_pkg::*;
   localparam int CC = 20;
   logic       clk        = 1'b0;
   logic       rst        = 1'b1;
   logic       fault_in   = 1'b0;
   albk_req_t  req        = '0;
   logic [7:0] rdata;
   logic [7:0] level;
   logic       alarm;
   logic       cycle_tick;
   logic       al         = 1'b0;
   int         fail_count = 0;
   int         n_checks   = 0;
   int         ncyc       = 0;
   int         run        = 0;
   int         lvl        = 0;
   int         mx         = 8;
   int         sel        = 1;
   always #50 clk = ~clk;
   albk_bucket #(.CYCLE_CLKS_P(CC)) u_dut (
      .clk(clk), .rst(rst), .fault_in(fault_in), .req(req),
      .rdata(rdata), .level(level), .alarm(alarm), .cycle_tick(cycle_tick));
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge clk);
      req.wr = 1'b0;
      @(negedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge clk);
      req.rd = 1'b0;
      chk(rdata, e, "read");
      @(negedge clk);
   endtask
   // wait for end of monitoring cycle, bounded
   task automatic wt;
      int n;
      n = 0;
      while (cycle_tick !== 1'b1 && n < 2 * CC) begin
         @(negedge clk);
         n++;
      end
      chk(8'(n < 2 * CC), 8'h01, "tick");
      @(negedge clk);
   endtask
   // one monitoring cycle, fault pulse kept inside it
   task automatic cyc(input logic f);
      repeat (3) @(negedge clk);
      fault_in = f;
      repeat (3) @(negedge clk);
      fault_in = 1'b0;
      wt();
      if (f) begin
         lvl = (lvl + 1 > mx) ? mx : lvl + 1;
         run = 0;
      end else if (++run == (1 << sel)) begin
         run = 0;
         if (lvl > 0) lvl--;
      end
      if (lvl >= int'(RST_UPPER_THR)) al = 1'b1;
      else if (lvl <= int'(RST_LOWER_THR)) al = 1'b0;
      chk(level, 8'(lvl), "level");
      chk({7'h00, alarm}, {7'h00, al}, "alarm");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      ncyc++;
      if (ncyc == 5000) begin
         $display("Error %0t: timeout", $time);
         fail_count++;
         end_sim();
      end
   end
   initial begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      rd(ADDR_UPPER_THR, RST_UPPER_THR);
      rd(ADDR_LOWER_THR, RST_LOWER_THR);
      rd(ADDR_MAX_COUNT, RST_MAX_COUNT);
      rd(ADDR_LEAK_RATE, RST_LEAK_RATE);
      wr(ADDR_STATUS, 8'hFF);
      rd(ADDR_STATUS, 8'h00);
      wr(8'h60, 8'hFF);
      rd(8'h60, 8'h00);
      wr(ADDR_LEAK_RATE, 8'hFF);
      rd(ADDR_LEAK_RATE, 8'h03);
      sel = 3;
      $display("test regs done");
      wt();
      repeat (10) cyc(1'b1);
      rd(ADDR_STATUS, 8'h01);
      $display("test fill done");
      for (int s = 0; s < 4; s++) begin
         wr(ADDR_LEAK_RATE, 8'(s));
         sel = s;
         cyc(1'b1);
         repeat (2 << s) cyc(1'b0);
      end
      $display("test decay done");
      wr(ADDR_LEAK_RATE, 8'h00);
      sel = 0;
      repeat (5) cyc(1'b0);
      wr(ADDR_MAX_COUNT, 8'h03);
      mx = 3;
      repeat (5) cyc(1'b1);
      wr(ADDR_MAX_COUNT, 8'h01);
      mx = 1;
      cyc(1'b1);
      $display("test floor and limit done");
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      chk(level, 8'h00, "reset level");
      chk({7'h00, alarm}, 8'h00, "reset alarm");
      rd(ADDR_MAX_COUNT, RST_MAX_COUNT);
      rd(ADDR_LEAK_RATE, RST_LEAK_RATE);
      $display("test reset done");
      end_sim();
   end
endmodule
`default_nettype wire
